//--- serial_irq_pkg.sv
// package: register map, field positions and reset values of the serial channel gating block
package serial_irq_pkg;

  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] SERIAL_CONTROL_OFF  = 8'h00;
  localparam logic [ADDR_W-1:0] GROUP_SRC_MASK_OFF  = 8'h04;
  localparam logic [ADDR_W-1:0] CTRL_MASK_A_OFF     = 8'h08;
  localparam logic [ADDR_W-1:0] CTRL_MASK_B_OFF     = 8'h0c;
  localparam logic [ADDR_W-1:0] PENDING_FLAG_OFF    = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF      = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF        = 8'h18;
  localparam logic [ADDR_W-1:0] TX_DATA_OFF         = 8'h1c;
  localparam logic [ADDR_W-1:0] RX_DATA_OFF         = 8'h20;
  localparam logic [ADDR_W-1:0] CHAN_STATE_OFF      = 8'h24;

  // serial_control fields
  localparam int unsigned TX_ON_BIT           = 0;
  localparam int unsigned RX_ON_BIT           = 1;
  localparam int unsigned TX_EMPTY_IRQ_ON_BIT = 2;
  localparam int unsigned RX_IRQ_ON_BIT       = 3;
  localparam int unsigned TX_DONE_IRQ_ON_BIT  = 4;
  localparam logic [4:0]  SERIAL_CONTROL_MASK = 5'h1f;

  // source positions in irq status and irq mask; pending_flag holds only the lower four (no SRC_RX_DROP)
  localparam int unsigned SRC_RX_FULL  = 0;
  localparam int unsigned SRC_TX_EMPTY = 1;
  localparam int unsigned SRC_TX_DONE  = 2;
  localparam int unsigned SRC_GROUP    = 3;
  localparam int unsigned SRC_RX_DROP  = 4;
  localparam int unsigned PEND_W       = 4;
  localparam int unsigned STAT_W       = 5;

  // ctrl_mask_reg_b fields
  localparam int unsigned RX_LINE_BIT       = 0;
  localparam int unsigned TX_EMPTY_LINE_BIT = 1;
  localparam int unsigned TX_DONE_LINE_BIT  = 2;

  // chan_state fields; bit 3 is write-one-to-clear for the receive error
  localparam int unsigned ST_TX_PENDING_BIT = 0;
  localparam int unsigned ST_RX_FULL_BIT    = 1;
  localparam int unsigned ST_TX_EMPTY_BIT   = 2;
  localparam int unsigned ST_RX_ERROR_BIT   = 3;

  // reset values: everything off
  localparam logic [4:0] SERIAL_CONTROL_RST = 5'h00;
  localparam logic [2:0] CTRL_MASK_B_RST    = 3'h0;
  localparam logic [4:0] IRQ_MASK_RST       = 5'h00;
  localparam logic [7:0] DATA_RST           = 8'h00;

endpackage

//--- flag_bank.sv
// module: bank of sticky flags where a set in the same cycle beats a clear
module flag_bank #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] flags_out
);

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // set wins so an event landing on the clearing write is never lost
  assign flags_nxt = (flags_r & ~clr_in) | set_in;
  assign flags_out = flags_r;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule

//--- serial_channel_irq_gating.sv
// module: enables, data holding and two-level interrupt gating of one serial channel, wishbone slave
// Contract
// - transmit-on cleared: no transmission at all on the channel
// - receive-on cleared: reception off, no incoming frame accepted
// - transmit-empty enable cleared: no transmit-empty request raised
// - one receive enable gates both receive-full and receive-error requests
// - transmit-done enable cleared: no transmit-done request after last frame
// - writing zero to serial control clears all its enables together
// - receive-error request enters shared group only through group source bit
// - controller group line enable blocks the whole shared group request
// - controller receive line enable blocks the receive-full request
// - controller line enables block transmit-empty and transmit-done requests
// - controller keeps pending flag per source; writing zero clears it
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
module serial_channel_irq_gating
  import serial_irq_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  // wishbone classic slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADDR_W-1:0] wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  // shifter side, same clock
  output logic                   tx_enable_out,
  output logic                   tx_valid_out,
  output logic      [7:0]        tx_data_out,
  input  wire logic              tx_ready_in,
  input  wire logic              tx_idle_in,
  output logic                   rx_enable_out,
  input  wire logic              rx_valid_in,
  input  wire logic [7:0]        rx_data_in,
  input  wire logic              rx_error_in,
  // processor side request lines
  output logic      [PEND_W-1:0] pending_out,
  output logic                   irq_out
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] off);
    reg_hit = (adr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  logic        ack_r;
  logic [31:0] rdata_r;
  logic        req;
  logic        fire;
  logic        wr_fire;
  logic        rd_fire;
  logic        lane0_wr;

  // ack one cycle after the request, dropped right after; the master holds until then
  assign req      = wb_cyc_in & wb_stb_in;
  assign fire     = req & ack_r;
  assign wr_fire  = fire & wb_we_in;
  assign rd_fire  = fire & ~wb_we_in;
  assign lane0_wr = wr_fire & wb_sel_in[0];

  // register write strobes, only byte lane 0 carries data
  logic wr_ctrl;
  logic wr_gsrc;
  logic wr_mask_a;
  logic wr_mask_b;
  logic wr_pend;
  logic wr_stat;
  logic wr_imask;
  logic wr_txd;
  logic wr_state;
  logic rd_rxd;

  assign wr_ctrl   = lane0_wr & reg_hit(wb_adr_in, SERIAL_CONTROL_OFF);
  assign wr_gsrc   = lane0_wr & reg_hit(wb_adr_in, GROUP_SRC_MASK_OFF);
  assign wr_mask_a = lane0_wr & reg_hit(wb_adr_in, CTRL_MASK_A_OFF);
  assign wr_mask_b = lane0_wr & reg_hit(wb_adr_in, CTRL_MASK_B_OFF);
  assign wr_pend   = lane0_wr & reg_hit(wb_adr_in, PENDING_FLAG_OFF);
  assign wr_stat   = lane0_wr & reg_hit(wb_adr_in, IRQ_STATUS_OFF);
  assign wr_imask  = lane0_wr & reg_hit(wb_adr_in, IRQ_MASK_OFF);
  assign wr_txd    = lane0_wr & reg_hit(wb_adr_in, TX_DATA_OFF);
  assign wr_state  = lane0_wr & reg_hit(wb_adr_in, CHAN_STATE_OFF);
  assign rd_rxd    = rd_fire & reg_hit(wb_adr_in, RX_DATA_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [4:0] serial_control_r;
  logic       group_source_mask_r;
  logic       ctrl_mask_reg_a_r;
  logic [2:0] ctrl_mask_reg_b_r;
  logic [4:0] irq_mask_r;

  logic tx_on;
  logic rx_on;
  logic tx_empty_irq_on;
  logic rx_irq_on;
  logic tx_done_irq_on;
  logic channel_source_bit;
  logic group_line_on;
  logic rx_line_on;
  logic tx_empty_line_on;
  logic tx_done_line_on;

  assign tx_on              = serial_control_r[TX_ON_BIT];
  assign rx_on              = serial_control_r[RX_ON_BIT];
  assign tx_empty_irq_on    = serial_control_r[TX_EMPTY_IRQ_ON_BIT];
  assign rx_irq_on          = serial_control_r[RX_IRQ_ON_BIT];
  assign tx_done_irq_on     = serial_control_r[TX_DONE_IRQ_ON_BIT];
  assign channel_source_bit = group_source_mask_r;
  assign group_line_on      = ctrl_mask_reg_a_r;
  assign rx_line_on         = ctrl_mask_reg_b_r[RX_LINE_BIT];
  assign tx_empty_line_on   = ctrl_mask_reg_b_r[TX_EMPTY_LINE_BIT];
  assign tx_done_line_on    = ctrl_mask_reg_b_r[TX_DONE_LINE_BIT];

  // whole-register write
  // the control byte is loaded as a whole, so writing zero drops every enable at once
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      serial_control_r    <= SERIAL_CONTROL_RST;
      group_source_mask_r <= 1'b0;
      ctrl_mask_reg_a_r   <= 1'b0;
      ctrl_mask_reg_b_r   <= CTRL_MASK_B_RST;
      irq_mask_r          <= IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) serial_control_r <= wb_dat_in[4:0] & SERIAL_CONTROL_MASK;
      if (wr_gsrc) group_source_mask_r <= wb_dat_in[0];
      if (wr_mask_a) ctrl_mask_reg_a_r <= wb_dat_in[0];
      if (wr_mask_b) ctrl_mask_reg_b_r <= wb_dat_in[2:0];
      if (wr_imask) irq_mask_r <= wb_dat_in[STAT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit holding register

  logic [7:0] tx_data_r;
  logic       tx_pending_r;
  logic       tx_take;

  // transmit gate
  // data may sit in the holding register, but nothing leaves while transmit is off
  assign tx_valid_out  = tx_pending_r & tx_on;
  assign tx_enable_out = tx_on;
  assign tx_data_out   = tx_data_r;
  assign tx_take       = tx_valid_out & tx_ready_in;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_data_r    <= DATA_RST;
      tx_pending_r <= 1'b0;
    end else if (wr_txd) begin
      tx_data_r    <= wb_dat_in[7:0];
      tx_pending_r <= 1'b1;
    end else if (tx_take) begin
      tx_pending_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive holding register

  logic [7:0] rx_data_r;
  logic       rx_full_r;
  logic       rx_err_r;
  logic       rx_accept;
  logic       rx_drop;

  // receive gate
  // frames arriving while receive is off are dropped and only counted as an event
  assign rx_enable_out = rx_on;
  assign rx_accept     = rx_valid_in & rx_on;
  assign rx_drop       = rx_valid_in & ~rx_on;

  // a new frame beats the read that frees the register in the same cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_data_r <= DATA_RST;
      rx_full_r <= 1'b0;
    end else if (rx_accept) begin
      rx_data_r <= rx_data_in;
      rx_full_r <= 1'b1;
    end else if (rd_rxd) begin
      rx_full_r <= 1'b0;
    end
  end

  // receive error is sticky until software writes one to its state bit; set wins
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_err_r <= 1'b0;
    end else if (rx_error_in & rx_on) begin
      rx_err_r <= 1'b1;
    end else if (wr_state & wb_dat_in[ST_RX_ERROR_BIT]) begin
      rx_err_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel-level requests

  logic rx_full_request;
  logic tx_empty_request;
  logic tx_done_request;
  logic rx_error_request;
  logic shared_error_group;

  // transmit requests
  // transmit requests only exist while transmit is on, so a disabled channel stays quiet
  assign tx_empty_request = tx_empty_irq_on & tx_on & ~tx_pending_r;
  assign tx_done_request  = tx_done_irq_on & tx_on & ~tx_pending_r & tx_idle_in;

  assign rx_full_request  = rx_irq_on & rx_full_r;
  assign rx_error_request = rx_irq_on & rx_err_r;

  assign shared_error_group = rx_error_request & channel_source_bit;

  ////////////////////////////////////////////////////////////////////////////
  // controller-level gating and pending flags

  logic [PEND_W-1:0] pend_set;
  logic [PEND_W-1:0] pend_clr;
  logic [PEND_W-1:0] pending_flag;

  // controller line enables
  // requests are levels, so a cleared flag sets again while its source stays active
  assign pend_set[SRC_RX_FULL]  = rx_full_request & rx_line_on;
  assign pend_set[SRC_TX_EMPTY] = tx_empty_request & tx_empty_line_on;
  assign pend_set[SRC_TX_DONE]  = tx_done_request & tx_done_line_on;
  assign pend_set[SRC_GROUP]    = shared_error_group & group_line_on;

  assign pend_clr = {PEND_W{wr_pend}} & ~wb_dat_in[PEND_W-1:0];

  flag_bank #(
    .WIDTH (PEND_W)
  ) pend_bank (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .set_in    (pend_set),
    .clr_in    (pend_clr),
    .flags_out (pending_flag)
  );

  assign pending_out = pending_flag;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, and the masked level output

  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic [STAT_W-1:0] irq_status;

  assign stat_set = {rx_drop, pend_set};
  assign stat_clr = {STAT_W{wr_stat}} & wb_dat_in[STAT_W-1:0];

  flag_bank #(
    .WIDTH (STAT_W)
  ) stat_bank (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .set_in    (stat_set),
    .clr_in    (stat_clr),
    .flags_out (irq_status)
  );

  assign irq_out = |(irq_status & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered on the request cycle; unmapped addresses read zero

  logic [7:0] rd_byte;
  logic [7:0] chan_state;

  assign chan_state = {4'h0, rx_err_r, ~tx_pending_r & tx_on, rx_full_r, tx_pending_r};
  assign rd_byte =
    reg_hit(wb_adr_in, SERIAL_CONTROL_OFF) ? {3'h0, serial_control_r} :
    reg_hit(wb_adr_in, GROUP_SRC_MASK_OFF) ? {7'h00, group_source_mask_r} :
    reg_hit(wb_adr_in, CTRL_MASK_A_OFF)    ? {7'h00, ctrl_mask_reg_a_r} :
    reg_hit(wb_adr_in, CTRL_MASK_B_OFF)    ? {5'h00, ctrl_mask_reg_b_r} :
    reg_hit(wb_adr_in, PENDING_FLAG_OFF)   ? {4'h0, pending_flag} :
    reg_hit(wb_adr_in, IRQ_STATUS_OFF)     ? {3'h0, irq_status} :
    reg_hit(wb_adr_in, IRQ_MASK_OFF)       ? {3'h0, irq_mask_r} :
    reg_hit(wb_adr_in, TX_DATA_OFF)        ? tx_data_r :
    reg_hit(wb_adr_in, RX_DATA_OFF)        ? rx_data_r :
    reg_hit(wb_adr_in, CHAN_STATE_OFF)     ? chan_state : 8'h00;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req & ~ack_r;
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_tx_stays_off: assert property (!tx_on |-> !tx_valid_out && !tx_enable_out && !tx_take)
    else $error("transmit active while transmit is off");
  a_rx_refuses_frame: assert property (!rx_on && rx_valid_in |=> $stable(rx_data_r))
    else $error("frame accepted while receive is off");
  a_txe_req_gated: assert property (!tx_empty_irq_on |-> !tx_empty_request && !pend_set[SRC_TX_EMPTY])
    else $error("transmit-empty request with its enable off");
  a_rx_req_gated: assert property (!rx_irq_on |-> !rx_full_request && !rx_error_request)
    else $error("receive request with receive enable off");
  a_txd_req_gated: assert property (!tx_done_irq_on |-> !tx_done_request && !pend_set[SRC_TX_DONE])
    else $error("transmit-done request with its enable off");
  a_ctrl_zero_write: assert property (wr_ctrl && wb_dat_in[7:0] == 8'h00 |=> serial_control_r == 5'h00
    && !tx_enable_out && !rx_enable_out) else $error("zero write left an enable set");
  a_group_src_block: assert property (!channel_source_bit |-> !shared_error_group)
    else $error("error request passed a closed group source bit");
  a_group_line_block: assert property (!group_line_on && !pending_flag[SRC_GROUP]
    |=> !pending_flag[SRC_GROUP]) else $error("group pending set with group line off");
  a_rx_line_block: assert property (!rx_line_on && !pending_flag[SRC_RX_FULL]
    |=> !pending_flag[SRC_RX_FULL]) else $error("receive pending set with its line off");
  a_tx_line_block: assert property ((!tx_empty_line_on && !pending_flag[SRC_TX_EMPTY]
    |=> !pending_flag[SRC_TX_EMPTY]) and (!tx_done_line_on && !pending_flag[SRC_TX_DONE]
    |=> !pending_flag[SRC_TX_DONE])) else $error("transmit pending set with its line off");
  a_pend_zero_clear: assert property (wr_pend && !wb_dat_in[SRC_RX_FULL] && !pend_set[SRC_RX_FULL]
    |=> !pending_flag[SRC_RX_FULL]) else $error("zero write did not clear pending flag");
  a_pend_both_levels: assert property ($rose(pending_flag[SRC_GROUP]) |-> $past(rx_irq_on) &&
    $past(channel_source_bit) && $past(group_line_on)) else $error("group pending without all enables");

endmodule

//--- serial_far_model.sv
// model of the remote serial shifter pair beside the gating block
module serial_far_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       slow_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  output logic            tx_idle_out,
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  output logic            rx_error_out,
  input  wire logic       frame_go_in,
  input  wire logic       frame_err_in,
  input  wire logic [7:0] frame_byte_in,
  output logic      [7:0] taken_count_out,
  output logic      [7:0] last_byte_out
);
  logic [2:0] busy_r;
  logic [7:0] cnt_r;
  logic [7:0] last_r;
  logic [7:0] rxd_r;
  logic       rxv_r;
  logic       rxe_r;

  ////////////////////////////////////////////////////////////////////////////////
  // outputs; a released data line shows the inverse so a stale byte never matches
  assign tx_ready_out    = (busy_r == 3'h0) & ~slow_in;
  assign tx_idle_out     = (busy_r == 3'h0);
  assign rx_valid_out    = rxv_r;
  assign rx_error_out    = rxe_r;
  assign rx_data_out     = rxv_r ? rxd_r : ~rxd_r;
  assign taken_count_out = cnt_r;
  assign last_byte_out   = last_r;

  // a taken byte keeps the shifter busy for a few cycles, like a real frame
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      busy_r <= 3'h0;
      cnt_r  <= 8'h00;
      last_r <= 8'h00;
      rxd_r  <= 8'h00;
      rxv_r  <= 1'b0;
      rxe_r  <= 1'b0;
    end else begin
      rxv_r <= frame_go_in & ~frame_err_in;
      rxe_r <= frame_go_in & frame_err_in;
      if (frame_go_in) begin
        rxd_r <= frame_byte_in;
      end
      if (tx_valid_in & tx_ready_out) begin
        busy_r <= 3'h5;
        cnt_r  <= cnt_r + 8'h01;
        last_r <= tx_data_in;
      end else if (busy_r != 3'h0) begin
        busy_r <= busy_r - 3'h1;
      end
    end
  end
endmodule

//--- serial_channel_irq_gating_test.sv
// self-checking bench for the serial channel gating block
module serial_channel_irq_gating_test
  import serial_irq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0, srst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, wdat = 8'h00, fbyte = 8'h00, taken, last;
  logic slow = 1'b0, fgo = 1'b0, ferr = 1'b0;
  logic [31:0] dat_out;
  logic ack, tx_en, tx_val, tx_rdy, tx_idle, rx_en, rx_val, rx_err, irq;
  logic [7:0] tx_dat, rx_dat;
  logic [PEND_W-1:0] pend;
  int fails = 0, n_compared = 0;

  always #4 clk_in = ~clk_in;

  serial_channel_irq_gating i_serial_channel_irq_gating (.clk_in(clk_in), .srst_in(srst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1),
    .wb_dat_in({24'h000000, wdat}), .wb_dat_out(dat_out), .wb_ack_out(ack),
    .tx_enable_out(tx_en), .tx_valid_out(tx_val), .tx_data_out(tx_dat), .tx_ready_in(tx_rdy),
    .tx_idle_in(tx_idle), .rx_enable_out(rx_en), .rx_valid_in(rx_val), .rx_data_in(rx_dat),
    .rx_error_in(rx_err), .pending_out(pend), .irq_out(irq));

  serial_far_model i_serial_far_model (.clk_in(clk_in), .srst_in(srst_in), .slow_in(slow),
    .tx_valid_in(tx_val), .tx_data_in(tx_dat), .tx_ready_out(tx_rdy), .tx_idle_out(tx_idle),
    .rx_valid_out(rx_val), .rx_data_out(rx_dat), .rx_error_out(rx_err), .frame_go_in(fgo),
    .frame_err_in(ferr), .frame_byte_in(fbyte), .taken_count_out(taken), .last_byte_out(last));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run, also reached when a wait runs out
  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled high, bounded so a dead slave ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    r = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    check(r, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one received frame, or an error pulse, from the far side
  task automatic frame(input logic [7:0] b, input logic e);
    @(posedge clk_in);
    fgo <= 1'b1;
    ferr <= e;
    fbyte <= b;
    @(posedge clk_in);
    fgo <= 1'b0;
    idle(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(20);
    srst_in <= 1'b0;
    rd_chk(SERIAL_CONTROL_OFF, 32'h0);
    rd_chk(CTRL_MASK_B_OFF, 32'h0);
    rd_chk(8'h3c, 32'h0);
    // byte kept while transmit is off, then sent past a stalling shifter
    slow <= 1'b1;
    wr(TX_DATA_OFF, 8'ha5);
    idle(8);
    check(tx_val, 1'b0);
    rd_chk(CHAN_STATE_OFF, 32'h1);
    wr(SERIAL_CONTROL_OFF, 8'h01);
    idle(5);
    check({tx_en, tx_val, taken}, {2'b11, 8'h00});
    slow <= 1'b0;
    idle(10);
    check({taken, last}, {8'h01, 8'ha5});
    // transmit requests with channel enables off, then controller lines off
    wr(CTRL_MASK_B_OFF, 8'h07);
    idle(3);
    check(pend, 4'h0);
    wr(CTRL_MASK_B_OFF, 8'h00);
    wr(SERIAL_CONTROL_OFF, 8'h15);
    idle(3);
    check(pend, 4'h0);
    wr(CTRL_MASK_B_OFF, 8'h06);
    idle(3);
    check(pend, 4'h6);
    wr(IRQ_MASK_OFF, 8'h02);
    idle(2);
    check(irq, 1'b1);
    rd_chk(IRQ_STATUS_OFF, 32'h6);
    wr(IRQ_MASK_OFF, 8'h00);
    idle(2);
    check(irq, 1'b0);
    wr(SERIAL_CONTROL_OFF, 8'h01);
    // the clear lands on the ack edge, so let one edge pass before looking
    wr(PENDING_FLAG_OFF, 8'h04);
    idle(1);
    check(pend, 4'h4);
    wr(PENDING_FLAG_OFF, 8'h00);
    wr(IRQ_STATUS_OFF, 8'h06);
    rd_chk(IRQ_STATUS_OFF, 32'h0);
    // receive off drops the frame; receive enable gates the full request
    wr(CTRL_MASK_B_OFF, 8'h01);
    wr(SERIAL_CONTROL_OFF, 8'h08);
    frame(8'h3c, 1'b0);
    check({rx_en, pend}, 5'h00);
    rd_chk(IRQ_STATUS_OFF, 32'h10);
    wr(IRQ_STATUS_OFF, 8'h10);
    wr(SERIAL_CONTROL_OFF, 8'h02);
    frame(8'h3c, 1'b0);
    check(pend, 4'h0);
    rd_chk(RX_DATA_OFF, 32'h3c);
    wr(CTRL_MASK_B_OFF, 8'h00);
    wr(SERIAL_CONTROL_OFF, 8'h0a);
    frame(8'h5a, 1'b0);
    check(pend, 4'h0);
    wr(CTRL_MASK_B_OFF, 8'h01);
    idle(3);
    check(pend, 4'h1);
    rd_chk(RX_DATA_OFF, 32'h5a);
    wr(PENDING_FLAG_OFF, 8'h00);
    idle(1);
    check(pend, 4'h0);
    // receive error through the shared group, each gate in turn
    wr(SERIAL_CONTROL_OFF, 8'h02);
    wr(GROUP_SRC_MASK_OFF, 8'h01);
    wr(CTRL_MASK_A_OFF, 8'h01);
    frame(8'h00, 1'b1);
    check(pend, 4'h0);
    rd_chk(CHAN_STATE_OFF, 32'h8);
    wr(GROUP_SRC_MASK_OFF, 8'h00);
    wr(SERIAL_CONTROL_OFF, 8'h0a);
    idle(3);
    check(pend, 4'h0);
    // close the group line before reopening the source bit, or the group sets in between
    wr(CTRL_MASK_A_OFF, 8'h00);
    wr(GROUP_SRC_MASK_OFF, 8'h01);
    idle(3);
    check(pend, 4'h0);
    wr(CTRL_MASK_A_OFF, 8'h01);
    wr(IRQ_MASK_OFF, 8'h08);
    idle(3);
    check({irq, pend}, 5'h18);
    wr(CHAN_STATE_OFF, 8'h08);
    wr(PENDING_FLAG_OFF, 8'h00);
    wr(IRQ_STATUS_OFF, 8'h1f);
    idle(2);
    check({irq, pend}, 5'h00);
    // whole control register cleared at once
    wr(SERIAL_CONTROL_OFF, 8'hff);
    rd_chk(SERIAL_CONTROL_OFF, 32'h1f);
    wr(SERIAL_CONTROL_OFF, 8'h00);
    rd_chk(SERIAL_CONTROL_OFF, 32'h0);
    check({tx_en, rx_en}, 2'b00);
    report_and_stop();
  end
endmodule
